/* File: pkg/fti_pkg.sv */
// Behaviour
// - one 64 by 8 byte buffer
// - host data write stores, advances write pointer
// - host data read returns byte, advances read
// - fill count is write minus read distance
// - host access wins when clashing with core buffer use
// - flush resets pointers, count, overflow flag
// - write when full sets sticky overflow flag
// - high alert when free space <= watermark
// - low alert when fill count <= watermark
// - alert rising sets its event flag
// - timer ticks 13.56 MHz, 12-bit prescaler
// - 16-bit counter reload, count always readable
// - 1 to 0 sets expiry; halt or reload
// - start, stop, auto start, running status
// - period (2P+1)*(R+1) timer ticks
// - expiry only raises flags
// - pending event sets summary bit, drives pin
// - end-of-frame entry sets transmit done
// - checksum ready sets checksum done
// - receive end and command idle flags
// - field on, field off, mode detect flags
// - any error bit sets error flag
`default_nettype none
package fti_pkg;
   // ----------------------------------------
   // bus shape
   // ----------------------------------------
   localparam int DW = 16;
   localparam int AW = 4;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [AW-1:0] REG_DATA = 4'h0;
   localparam logic [AW-1:0] REG_LEVEL = 4'h1;
   localparam logic [AW-1:0] REG_WATER = 4'h2;
   localparam logic [AW-1:0] REG_STATUS = 4'h3;
   localparam logic [AW-1:0] REG_ERROR = 4'h4;
   localparam logic [AW-1:0] REG_IEN = 4'h5;
   localparam logic [AW-1:0] REG_FLAGS = 4'h6;
   localparam logic [AW-1:0] REG_TMODE = 4'h7;
   localparam logic [AW-1:0] REG_TPRESC = 4'h8;
   localparam logic [AW-1:0] REG_TIMER_COUNTER_RELOAD = 4'h9;
   localparam logic [AW-1:0] REG_TCOUNT = 4'hA;
   localparam logic [AW-1:0] REG_CTRL = 4'hB;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LVL_FLUSH = 15;
   localparam int IEN_ACT = 15;
   localparam int FLG_SET = 15;
   localparam int TM_RESTART = 0;
   localparam int TM_AUTO = 1;
   localparam int CTL_START = 0;
   localparam int CTL_STOP = 1;
   localparam int ST_IRQ = 0;
   localparam int ST_RUN = 1;
   localparam int ST_HI = 2;
   localparam int ST_LO = 3;
   localparam int ERR_W = 8;
   localparam int ERR_OVF = 0;
   // ----------------------------------------
   // event flag positions
   // ----------------------------------------
   localparam int EV_TIMER = 0;
   localparam int EV_TX = 1;
   localparam int EV_CRC = 2;
   localparam int EV_RX = 3;
   localparam int EV_IDLE = 4;
   localparam int EV_HI = 5;
   localparam int EV_LO = 6;
   localparam int EV_RFON = 7;
   localparam int EV_RFOFF = 8;
   localparam int EV_ERR = 9;
   localparam int EV_MODE = 10;
   localparam int NUM_EV = 11;
   // ----------------------------------------
   // buffer and timer sizes, rates
   // ----------------------------------------
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW = 6;
   localparam int PSC_W = 12;
   localparam int TCNT_W = 16;
   localparam int SYS_CLK_KHZ = 50000;
   localparam int TMR_CLK_KHZ = 13560;
   localparam int TICK_ACC_W = 17;
   // timer run state
   typedef enum logic [0:0] {
      FTI_T_IDLE = 1'b0,
      FTI_T_RUN = 1'b1
   } fti_tstate_t;
endpackage
`default_nettype wire

/* File: rtl/fti_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module fti_timer (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // tick and control
   input wire logic tick_in,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic restart_in,
   // reload values
   input wire logic [fti_pkg::PSC_W-1:0] psc_in,
   input wire logic [fti_pkg::TCNT_W-1:0] reload_in,
   // state out
   output logic [fti_pkg::TCNT_W-1:0] count_out,
   output logic running_out,
   output logic expire_out
);
   import fti_pkg::*;
   fti_tstate_t state; // run state
   logic [PSC_W:0] psc; // prescaler, 2P+1 ticks a step
   logic [PSC_W:0] psc_top; // doubled prescaler reload
   assign psc_top = {psc_in, 1'b0};
   assign running_out = (state == FTI_T_RUN);
   // ----------------------------------------
   // two-stage down counter
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      expire_out <= 1'b0;
      if (rst_in)
      begin
         state <= FTI_T_IDLE;
         psc <= '0;
         count_out <= '0;
      end
      else if (stop_in)
         state <= FTI_T_IDLE;
      else if (start_in)
      begin
         // load both stages
         state <= FTI_T_RUN;
         psc <= psc_top;
         count_out <= reload_in;
      end
      else
      begin
         case (state)
            FTI_T_IDLE:
               state <= FTI_T_IDLE;
            FTI_T_RUN:
               if (tick_in)
               begin
                  if (psc != '0)
                     psc <= psc - 1'b1;
                  else
                  begin
                     psc <= psc_top;
                     if (count_out == 16'h0001)
                     begin
                        // expiry step
                        count_out <= 16'h0000;
                        expire_out <= 1'b1;
                     end
                     else if (count_out == 16'h0000)
                     begin
                        // halt or reload at zero
                        if (restart_in)
                           count_out <= reload_in;
                        else
                           state <= FTI_T_IDLE;
                     end
                     else
                        count_out <= count_out - 1'b1;
                  end
               end
            default:
               state <= FTI_T_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_expire_step;
      @(posedge clk_in) disable iff (rst_in)
      expire_out |-> count_out == 16'h0000 && $past(count_out) == 16'h0001;
   endproperty
   a_expire_step: assert property (p_expire_step) else $error("expiry not on 1 to 0");
   property p_stop;
      @(posedge clk_in) disable iff (rst_in)
      stop_in |=> !running_out ##1 !expire_out;
   endproperty
   a_stop: assert property (p_stop) else $error("timer ran after stop");
   c_expire: cover property (@(posedge clk_in) disable iff (rst_in) expire_out);
endmodule // fti_timer
`default_nettype wire

/* File: rtl/fti_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module fti_unit #(
   parameter int DEPTH = fti_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [fti_pkg::AW-1:0] addr_in,
   input wire logic [fti_pkg::DW-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [fti_pkg::DW-1:0] rdata_out,
   // command engine buffer side
   input wire logic core_wr_in,
   input wire logic [7:0] core_wdata_in,
   input wire logic core_rd_in,
   output logic [7:0] core_rdata_out,
   // event sources
   input wire logic tx_eof_in,
   input wire logic crc_ready_in,
   input wire logic rx_end_in,
   input wire logic cmd_idle_in,
   input wire logic field_in,
   input wire logic mode_detect_in,
   input wire logic timer_trig_in,
   input wire logic [fti_pkg::ERR_W-2:0] err_in,
   // host interrupt pin and status
   output logic irq_out,
   output logic fifo_count_nz_out
);
   import fti_pkg::*;
   // ----------------------------------------
   // storage and state
   // ----------------------------------------
   logic [7:0] mem [DEPTH]; // shared byte buffer
   logic [FIFO_AW:0] wr_ptr; // write pointer with wrap bit
   logic [FIFO_AW:0] rd_ptr; // read pointer with wrap bit
   logic [FIFO_AW:0] count; // fill count
   logic [FIFO_AW:0] free; // free space
   logic [FIFO_AW-1:0] water; // watermark
   logic ovf; // overflow flag
   logic [ERR_W-2:0] err_ext; // sampled external errors
   logic [ERR_W-1:0] err_reg; // error flags register
   logic hi_now; // high alert level
   logic lo_now; // low alert level
   logic hi_q; // high alert last cycle
   logic lo_q; // low alert last cycle
   logic crc_q; // checksum ready last cycle
   logic field_q; // field level last cycle
   logic [NUM_EV-1:0] flags; // event flags
   logic [NUM_EV-1:0] ien; // event enables
   logic irq_act; // pin output activated
   logic [NUM_EV-1:0] hw_set; // hardware events this cycle
   logic pend; // any enabled flag pending
   logic restart; // timer reload at zero
   logic t_auto; // protocol auto start
   logic [PSC_W-1:0] psc_rl; // prescaler reload
   logic [TCNT_W-1:0] cnt_rl; // counter reload
   logic [TCNT_W-1:0] t_count; // present count
   logic t_run; // timer running
   logic t_exp; // timer expiry pulse
   logic [TICK_ACC_W-1:0] acc; // fractional tick divider
   logic tick; // 13.56 MHz tick enable
   logic [7:0] head; // byte at read pointer
   // ----------------------------------------
   // access decode
   // ----------------------------------------
   logic h_wr_data; // host writes data port
   logic h_rd_data; // host reads data port
   logic flush; // host flush
   logic do_wr; // buffer write this cycle
   logic do_rd; // buffer read this cycle
   logic full; // buffer full
   logic empty; // buffer empty
   logic [7:0] wbyte; // byte to store
   logic t_start; // timer start
   logic t_stop; // timer stop
   assign h_wr_data = wr_in && addr_in == REG_DATA;
   assign h_rd_data = rd_in && addr_in == REG_DATA;
   assign flush = wr_in && addr_in == REG_LEVEL && wdata_in[LVL_FLUSH];
   // host and engine share one buffer; host has priority
   assign do_wr = h_wr_data || core_wr_in;
   assign do_rd = h_rd_data || core_rd_in;
   assign wbyte = h_wr_data ? wdata_in[7:0] : core_wdata_in;
   assign count = wr_ptr - rd_ptr;
   assign free = 7'(DEPTH) - count;
   assign full = count == 7'(DEPTH);
   assign empty = count == '0;
   assign head = mem[rd_ptr[FIFO_AW-1:0]];
   assign hi_now = free <= {1'b0, water};
   assign lo_now = count <= {1'b0, water};
   assign err_reg = {err_ext, ovf};
   assign pend = |(flags & ien);
   assign t_start = (wr_in && addr_in == REG_CTRL && wdata_in[CTL_START]) || (t_auto && timer_trig_in);
   assign t_stop = wr_in && addr_in == REG_CTRL && wdata_in[CTL_STOP];
   // ----------------------------------------
   // buffer storage
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      // a full buffer drops the byte
      if (do_wr && !full && !flush)
         mem[wr_ptr[FIFO_AW-1:0]] <= wbyte;
   end
   // ----------------------------------------
   // pointers
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in || flush)
      begin
         // flush makes old bytes unreachable
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_wr && !full)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd && !empty)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
   // ----------------------------------------
   // overflow and error sampling
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ovf <= 1'b0;
         err_ext <= '0;
      end
      else
      begin
         err_ext <= err_in;
         // set wins over flush
         if (do_wr && full)
            ovf <= 1'b1;
         else if (flush)
            ovf <= 1'b0;
      end
   end
   // ----------------------------------------
   // engine read data
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         core_rdata_out <= 8'h00;
      else if (core_rd_in && !h_rd_data)
         core_rdata_out <= head;
   end
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         water <= '0;
         ien <= '0;
         irq_act <= 1'b0;
         restart <= 1'b0;
         t_auto <= 1'b0;
         psc_rl <= '0;
         cnt_rl <= '0;
      end
      else if (wr_in)
      begin
         if (addr_in == REG_WATER)
            water <= wdata_in[FIFO_AW-1:0];
         else if (addr_in == REG_IEN)
         begin
            ien <= wdata_in[NUM_EV-1:0];
            irq_act <= wdata_in[IEN_ACT];
         end
         else if (addr_in == REG_TMODE)
         begin
            restart <= wdata_in[TM_RESTART];
            t_auto <= wdata_in[TM_AUTO];
         end
         else if (addr_in == REG_TPRESC)
            psc_rl <= wdata_in[PSC_W-1:0];
         else if (addr_in == REG_TIMER_COUNTER_RELOAD)
            cnt_rl <= wdata_in;
      end
   end
   // ----------------------------------------
   // timer tick divider, average 13.56 MHz
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         acc <= '0;
         tick <= 1'b0;
      end
      else if (acc + TICK_ACC_W'(TMR_CLK_KHZ) >= TICK_ACC_W'(SYS_CLK_KHZ))
      begin
         acc <= acc + TICK_ACC_W'(TMR_CLK_KHZ) - TICK_ACC_W'(SYS_CLK_KHZ);
         tick <= 1'b1;
      end
      else
      begin
         acc <= acc + TICK_ACC_W'(TMR_CLK_KHZ);
         tick <= 1'b0;
      end
   end
   // timer stages; expiry only reaches the flags
   fti_timer u_timer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_in(tick),
      .start_in(t_start),
      .stop_in(t_stop),
      .restart_in(restart),
      .psc_in(psc_rl),
      .reload_in(cnt_rl),
      .count_out(t_count),
      .running_out(t_run),
      .expire_out(t_exp)
   );
   // ----------------------------------------
   // edge history
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hi_q <= 1'b0;
         lo_q <= 1'b1;
         crc_q <= 1'b0;
         field_q <= 1'b0;
      end
      else
      begin
         hi_q <= hi_now;
         lo_q <= lo_now;
         crc_q <= crc_ready_in;
         field_q <= field_in;
      end
   end
   // hardware event vector
   always_comb
   begin
      hw_set = '0;
      hw_set[EV_TIMER] = t_exp;
      hw_set[EV_TX] = tx_eof_in;
      hw_set[EV_CRC] = crc_ready_in && !crc_q;
      hw_set[EV_RX] = rx_end_in;
      hw_set[EV_IDLE] = cmd_idle_in;
      hw_set[EV_HI] = hi_now && !hi_q;
      hw_set[EV_LO] = lo_now && !lo_q;
      hw_set[EV_RFON] = field_in && !field_q;
      hw_set[EV_RFOFF] = !field_in && field_q;
      hw_set[EV_ERR] = |err_reg;
      hw_set[EV_MODE] = mode_detect_in;
   end
   // ----------------------------------------
   // event flags, host set or clear
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         flags <= '0;
      else if (wr_in && addr_in == REG_FLAGS)
      begin
         // hardware set wins over a host clear
         if (wdata_in[FLG_SET])
            flags <= flags | wdata_in[NUM_EV-1:0] | hw_set;
         else
            flags <= (flags & ~wdata_in[NUM_EV-1:0]) | hw_set;
      end
      else
         flags <= flags | hw_set;
   end
   // ----------------------------------------
   // interrupt pin and status outputs
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         irq_out <= 1'b0;
         fifo_count_nz_out <= 1'b0;
      end
      else
      begin
         irq_out <= irq_act && pend;
         fifo_count_nz_out <= !empty;
      end
   end
   // ----------------------------------------
   // register read, data one cycle later
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !rd_in)
         rdata_out <= '0;
      else if (addr_in == REG_DATA)
         rdata_out <= {8'h00, head};
      else if (addr_in == REG_LEVEL)
         rdata_out <= {9'h000, count};
      else if (addr_in == REG_WATER)
         rdata_out <= {10'h000, water};
      else if (addr_in == REG_STATUS)
         rdata_out <= {12'h000, lo_now, hi_now, t_run, pend};
      else if (addr_in == REG_ERROR)
         rdata_out <= {8'h00, err_reg};
      else if (addr_in == REG_IEN)
         rdata_out <= {irq_act, 4'h0, ien};
      else if (addr_in == REG_FLAGS)
         rdata_out <= {5'h00, flags};
      else if (addr_in == REG_TMODE)
         rdata_out <= {14'h0000, t_auto, restart};
      else if (addr_in == REG_TPRESC)
         rdata_out <= {4'h0, psc_rl};
      else if (addr_in == REG_TIMER_COUNTER_RELOAD)
         rdata_out <= cnt_rl;
      else if (addr_in == REG_TCOUNT)
         rdata_out <= t_count;
      else
         rdata_out <= '0;
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_flush;
      @(posedge clk_in) disable iff (rst_in)
      // an engine write into a full buffer beside the flush sets overflow again
      (flush && !(core_wr_in && full)) |=> count == '0 && !ovf ##0 free == 7'(DEPTH);
   endproperty
   a_flush: assert property (p_flush) else $error("flush left data or overflow");
   property p_ovf;
      @(posedge clk_in) disable iff (rst_in)
      // sticky for two more cycles unless a flush came in between
      (h_wr_data && full) |=> ovf ##1 (ovf || $past(flush)) ##1 (ovf || $past(flush) || $past(flush, 2));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not held");
   property p_wr;
      @(posedge clk_in) disable iff (rst_in)
      (h_wr_data && !full && !core_rd_in) |=> count == $past(count) + 7'h01;
   endproperty
   a_wr: assert property (p_wr) else $error("write did not advance count");
   property p_rd;
      @(posedge clk_in) disable iff (rst_in)
      (h_rd_data && !empty) |=> rdata_out[7:0] == $past(head) && rd_ptr == $past(rd_ptr) + 7'h01;
   endproperty
   a_rd: assert property (p_rd) else $error("read byte or pointer wrong");
   property p_cap;
      @(posedge clk_in) disable iff (rst_in)
      count <= 7'(DEPTH);
   endproperty
   a_cap: assert property (p_cap) else $error("fill count above depth");
   property p_hi_flag;
      @(posedge clk_in) disable iff (rst_in)
      (hi_now && !hi_q) |=> flags[EV_HI];
   endproperty
   a_hi_flag: assert property (p_hi_flag) else $error("high alert flag missed");
   property p_lo_level;
      @(posedge clk_in) disable iff (rst_in)
      rd_in && addr_in == REG_STATUS |=> rdata_out[ST_LO] == ($past(count) <= {1'b0, $past(water)});
   endproperty
   a_lo_level: assert property (p_lo_level) else $error("low alert status wrong");
   property p_irq;
      @(posedge clk_in) disable iff (rst_in)
      ##1 irq_out == $past(irq_act && |(flags & ien));
   endproperty
   a_irq: assert property (p_irq) else $error("pin does not follow enabled flags");
   property p_err;
      @(posedge clk_in) disable iff (rst_in)
      ovf |=> flags[EV_ERR];
   endproperty
   a_err: assert property (p_err) else $error("error flag missed");
   property p_texp;
      @(posedge clk_in) disable iff (rst_in)
      t_exp |=> flags[EV_TIMER];
   endproperty
   a_texp: assert property (p_texp) else $error("timer flag missed");
   c_ovf: cover property (@(posedge clk_in) disable iff (rst_in) h_wr_data && full);
   c_irq: cover property (@(posedge clk_in) disable iff (rst_in) !irq_out ##1 irq_out);
   c_tflag: cover property (@(posedge clk_in) disable iff (rst_in) t_exp ##1 flags[EV_TIMER]);
endmodule // fti_unit
`default_nettype wire

/* File: sim/fti_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host side register master
// ----------------------------------------
module fti_host_model (
   // clock
   input wire logic clk_in,
   // register port
   output logic [fti_pkg::AW-1:0] addr_out,
   output logic [fti_pkg::DW-1:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire logic [fti_pkg::DW-1:0] rdata_in
);
   import fti_pkg::*;
   // bus idle at time zero
   initial
   begin
      addr_out = '0;
      wdata_out = '0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // one-cycle write; start and stop strobes go this way
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wdata_out <= ~d; // released bus shows no stale value
   endtask
   // one-cycle read, data caught in the cycle after; never beside an engine access
   task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule // fti_host_model
`default_nettype wire

/* File: sim/fti_unit_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module fti_unit_bench;
   import fti_pkg::*;
   // ----------------------------------------
   // clock, reset, stimulus
   // ----------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata, rdata, rv;
   logic wr, rd, irq, nz;
   logic cwr = 1'b0, crd = 1'b0, tx = 1'b0, crc = 1'b0, rx = 1'b0, idle = 1'b0;
   logic field = 1'b0, mode = 1'b0, trig = 1'b0;
   logic [7:0] cwd = 8'h00, crdat;
   logic [ERR_W-2:0] err = '0;
   int n_mismatch = 0, check_count = 0, cycles = 0, i;
   // 20 ns clock
   always #10 clk_in = ~clk_in;
   fti_host_model host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
      .rdata_in(rdata));
   fti_unit #(.DEPTH(64)) DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .core_wr_in(cwr), .core_wdata_in(cwd),
      .core_rd_in(crd), .core_rdata_out(crdat), .tx_eof_in(tx), .crc_ready_in(crc), .rx_end_in(rx),
      .cmd_idle_in(idle), .field_in(field), .mode_detect_in(mode), .timer_trig_in(trig),
      .err_in(err), .irq_out(irq), .fifo_count_nz_out(nz));
   // ----------------------------------------
   // compare, report
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // register read and compare under a mask
   task automatic rchk(input string what, input logic [AW-1:0] a, input logic [15:0] m,
      input logic [15:0] exp);
      host.rd_reg(a, rv);
      check(what, rv & m, exp);
   endtask
   // pin compare two edges after the cause
   task automatic pin(input logic exp);
      repeat (2) @(posedge clk_in);
      #1 check("irq", {15'h0000, irq}, {15'h0000, exp});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run;
      end
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      // reset state, unmapped place
      rchk("status", REG_STATUS, 16'hFFFF, 16'h0008);
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0000);
      rchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
      $display("test reset done");
      // host and engine writes share one buffer
      host.wr_reg(REG_DATA, 16'h00A1);
      host.wr_reg(REG_DATA, 16'h00A2);
      @(posedge clk_in);
      cwr <= 1'b1;
      cwd <= 8'h5A;
      @(posedge clk_in);
      cwr <= 1'b0;
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0003);
      check("nz", {15'h0000, nz}, 16'h0001);
      rchk("data", REG_DATA, 16'h00FF, 16'h00A1);
      rchk("data", REG_DATA, 16'h00FF, 16'h00A2);
      rchk("data", REG_DATA, 16'h00FF, 16'h005A);
      host.wr_reg(REG_DATA, 16'h0033);
      @(posedge clk_in);
      crd <= 1'b1;
      @(posedge clk_in);
      crd <= 1'b0;
      #1 check("core byte", {8'h00, crdat}, 16'h0033);
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0000);
      $display("test order done");
      // fill to full, overflow, flush, alerts
      host.wr_reg(REG_WATER, 16'h0002);
      host.wr_reg(REG_FLAGS, 16'h07FF);
      for (i = 0; i < 64; i++)
         host.wr_reg(REG_DATA, 16'(i));
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0040);
      rchk("alerts", REG_STATUS, 16'h000C, 16'h0004);
      host.wr_reg(REG_DATA, 16'h00FF);
      rchk("error", REG_ERROR, 16'hFFFF, 16'h0001);
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0040);
      rchk("data", REG_DATA, 16'h00FF, 16'h0000);
      host.wr_reg(REG_LEVEL, 16'h8000);
      rchk("level", REG_LEVEL, 16'hFFFF, 16'h0000);
      rchk("error", REG_ERROR, 16'hFFFF, 16'h0000);
      rchk("flags", REG_FLAGS, 16'h07FF, 16'h0260);
      host.wr_reg(REG_IEN, 16'h8040);
      pin(1'b1);
      rchk("summary", REG_STATUS, 16'h0001, 16'h0001);
      host.wr_reg(REG_FLAGS, 16'h0040);
      pin(1'b0);
      $display("test buffer done");
      // timer: 21 ticks a step, 2 steps, about 155 clocks to expiry
      host.wr_reg(REG_TPRESC, 16'h000A);
      host.wr_reg(REG_TIMER_COUNTER_RELOAD, 16'h0002);
      host.wr_reg(REG_TMODE, 16'h0000);
      host.wr_reg(REG_FLAGS, 16'h07FF);
      host.wr_reg(REG_CTRL, 16'h0001);
      rchk("count", REG_TCOUNT, 16'hFFFF, 16'h0002);
      rchk("run", REG_STATUS, 16'h0002, 16'h0002);
      repeat (110) @(posedge clk_in);
      rchk("count", REG_TCOUNT, 16'hFFFF, 16'h0001);
      rchk("flags", REG_FLAGS, 16'h07FF, 16'h0000);
      repeat (120) @(posedge clk_in);
      rchk("count", REG_TCOUNT, 16'hFFFF, 16'h0000);
      rchk("flags", REG_FLAGS, 16'h07FF, 16'h0001);
      rchk("run", REG_STATUS, 16'h0002, 16'h0000);
      host.wr_reg(REG_TMODE, 16'h0002);
      @(posedge clk_in);
      trig <= 1'b1;
      @(posedge clk_in);
      trig <= 1'b0;
      rchk("auto run", REG_STATUS, 16'h0002, 16'h0002);
      host.wr_reg(REG_CTRL, 16'h0002);
      rchk("stopped", REG_STATUS, 16'h0002, 16'h0000);
      // reload and continue: still running long after the first expiry
      host.wr_reg(REG_TMODE, 16'h0001);
      host.wr_reg(REG_CTRL, 16'h0001);
      repeat (300) @(posedge clk_in);
      rchk("reload run", REG_STATUS, 16'h0002, 16'h0002);
      host.wr_reg(REG_CTRL, 16'h0002);
      // host clears and sets the expiry flag
      host.wr_reg(REG_FLAGS, 16'h07FF);
      rchk("host clear", REG_FLAGS, 16'h0001, 16'h0000);
      host.wr_reg(REG_FLAGS, 16'h8001);
      rchk("host set", REG_FLAGS, 16'h0001, 16'h0001);
      $display("test timer done");
      // every external event source at once
      host.wr_reg(REG_FLAGS, 16'h07FF);
      host.wr_reg(REG_IEN, 16'h87FF);
      pin(1'b0);
      @(posedge clk_in);
      {tx, crc, rx, idle, mode, field} <= 6'h3F;
      err <= 7'h05;
      @(posedge clk_in);
      {tx, rx, idle, mode, field} <= 5'h00;
      rchk("error", REG_ERROR, 16'hFFFF, 16'h000A);
      err <= 7'h00;
      rchk("flags", REG_FLAGS, 16'h07FF, 16'h079E);
      pin(1'b1);
      $display("test events done");
      complete_run;
   end
endmodule // fti_unit_bench
`default_nettype wire
